// File: design/dma_channel_control.sv
// Purpose: Two-channel DMA control: start, restart, request flags, cycle cost
// Assumes: APB slave with zero wait states, inputs synchronous to pclk
// Notes:   Transfers are timed only; data moves on the memory bus elsewhere
// Summary of operation
// - Unit costs read cycles times j plus write cycles times k.
// - j,k: 1 fast memory, 2 waited or SFR, 3 multiplexed bus.
// - Byte units always take one read and one write cycle.
// - Word units: even on 16-bit bus one each, otherwise two each.
// - Source and destination parity are costed independently.
// - Writing one to enable makes the channel active.
// - First transfer loads forward pointer from the selected pointer.
// - First transfer copies reload value into the transfer counter.
// - Rewriting enable one restarts with both reloads.
// - Each channel requests from one preselected factor.
// - Factors: peripheral interrupts, software trigger, external pins.
// - Request flag sets on request whatever the enable state.
// - Hardware clears the flag just before the transfer starts.
// - Software writes zero to clear the flag; one does nothing.
// - Factor change may set the flag spuriously; not suppressed.
// - Active channel starts at once; enable shows activity.
// - Peripheral factor sets the flag with the interrupt request.
// - External factor triggers on its channel pin edge.
// - Channel 0 wins ties except right after its own transfer, where channel 1 wins; one processor cycle before channel 1.
`timescale 1ns/10ps
module dma_channel_control #(
    parameter int AW   = 20,
    parameter int CW   = 16,
    parameter int NPER = 8
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [dma_pkg::PAW-1:0]  paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic [NPER-1:0]          periph_irq,
    input  wire logic [dma_pkg::NCH-1:0]  external_interrupt_input,
    output logic                          dma_bus_own,
    output logic                          dma_chan,
    output logic      [AW-1:0]            dma_src_addr,
    output logic      [AW-1:0]            dma_dst_addr,
    output logic                          dma_unit_byte,
    output logic                          dma_done
);
    localparam int NCH = dma_pkg::NCH;
    localparam int AWD = dma_pkg::AREA_W;

    logic [NCH-1:0] en_r, first_r, flag_r, unit_r, fwdsel_r;
    logic [NCH-1:0] req, ready, start_c, fin_c, wr_c, swt_c;
    logic [AWD-1:0] srca_r [NCH];
    logic [AWD-1:0] dsta_r [NCH];
    logic [3:0]     fac_r  [NCH];
    logic [AW-1:0]  src_r  [NCH];
    logic [AW-1:0]  dst_r  [NCH];
    logic [AW-1:0]  fwd_r  [NCH];
    logic [CW-1:0]  rld_r  [NCH];
    logic [CW-1:0]  cnt_r  [NCH];
    logic           bus8_r;

    logic           wr, rd_setup, in_ch, sel_ch, mapped;
    logic [7:0]     roff;
    logic [31:0]    rdata;

    dma_pkg::eng_state_e state_r;
    logic           chan_r, pick, start, fin;
    logic [4:0]     busy_r, cost_total;
    logic [3:0]     src_cyc, dst_cyc;
    logic [AW-1:0]  fwd_eff, cur_src, cur_dst;

    // APB decode
    assign wr       = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign in_ch    = paddr < dma_pkg::OFF_CFG;
    assign sel_ch   = paddr[dma_pkg::CH_BIT];
    assign roff     = paddr & dma_pkg::OFF_MASK;
    assign pready   = 1'b1;

    always_comb begin
        mapped = 1'b0;
        if (in_ch) begin
            unique case (roff)
                dma_pkg::OFF_CTRL, dma_pkg::OFF_FACTOR, dma_pkg::OFF_SRC, dma_pkg::OFF_DST,
                dma_pkg::OFF_RELOAD, dma_pkg::OFF_COUNT, dma_pkg::OFF_FWD: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end else if (paddr == dma_pkg::OFF_CFG) begin
            mapped = 1'b1;
        end
    end

    assign pslverr = psel & penable & ~mapped;

    // Read data is fetched in the setup cycle so it stands in a flop
    always_comb begin
        rdata = '0;
        if (in_ch) begin
            unique case (roff)
                dma_pkg::OFF_CTRL: begin
                    rdata[dma_pkg::B_EN]   = en_r[sel_ch];
                    rdata[dma_pkg::B_UNIT] = unit_r[sel_ch];
                    rdata[dma_pkg::B_FWD]  = fwdsel_r[sel_ch];
                    rdata[dma_pkg::B_REQ]  = flag_r[sel_ch];
                    rdata[dma_pkg::B_SRCA +: AWD] = srca_r[sel_ch];
                    rdata[dma_pkg::B_DSTA +: AWD] = dsta_r[sel_ch];
                end
                dma_pkg::OFF_FACTOR: rdata[3:0]    = fac_r[sel_ch];
                dma_pkg::OFF_SRC:    rdata[AW-1:0] = src_r[sel_ch];
                dma_pkg::OFF_DST:    rdata[AW-1:0] = dst_r[sel_ch];
                dma_pkg::OFF_RELOAD: rdata[CW-1:0] = rld_r[sel_ch];
                dma_pkg::OFF_COUNT:  rdata[CW-1:0] = cnt_r[sel_ch];
                dma_pkg::OFF_FWD:    rdata[AW-1:0] = fwd_r[sel_ch];
                default:             rdata = '0;
            endcase
        end else if (paddr == dma_pkg::OFF_CFG) begin
            rdata[dma_pkg::B_BUS8] = bus8_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (rd_setup) begin
            prdata <= rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus8_r <= 1'b0;
        end else if (wr && paddr == dma_pkg::OFF_CFG) begin
            bus8_r <= pwdata[dma_pkg::B_BUS8];
        end
    end

    // Per-channel state, fully separate
    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            logic wr_ctrl, en_one;
            assign wr_c[c]  = wr & in_ch & (sel_ch == 1'(c));
            assign wr_ctrl  = wr_c[c] & (roff == dma_pkg::OFF_CTRL);
            assign en_one   = wr_ctrl & pwdata[dma_pkg::B_EN];
            assign swt_c[c] = wr_ctrl & pwdata[dma_pkg::B_SWT];
            assign ready[c] = en_r[c] & flag_r[c];
            assign start_c[c] = start & (pick == 1'(c));
            assign fin_c[c]   = fin & (chan_r == 1'(c));

            dma_req_sel #(.NPER(NPER)) u_sel (
                .pclk       (pclk),
                .presetn    (presetn),
                .factor     (fac_r[c]),
                .periph_irq (periph_irq),
                .sw_trig    (swt_c[c]),
                .ext_in     (external_interrupt_input[c]),
                .req_pulse  (req[c])
            );

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    unit_r[c]   <= 1'b0;
                    fwdsel_r[c] <= 1'b0;
                    srca_r[c]   <= '0;
                    dsta_r[c]   <= '0;
                    fac_r[c]    <= '0;
                    src_r[c]    <= '0;
                    dst_r[c]    <= '0;
                    rld_r[c]    <= '0;
                end else if (wr_c[c]) begin
                    unique case (roff)
                        dma_pkg::OFF_CTRL: begin
                            unit_r[c]   <= pwdata[dma_pkg::B_UNIT];
                            fwdsel_r[c] <= pwdata[dma_pkg::B_FWD];
                            srca_r[c]   <= pwdata[dma_pkg::B_SRCA +: AWD];
                            dsta_r[c]   <= pwdata[dma_pkg::B_DSTA +: AWD];
                        end
                        dma_pkg::OFF_FACTOR: fac_r[c] <= pwdata[3:0];
                        dma_pkg::OFF_SRC:    src_r[c] <= pwdata[AW-1:0];
                        dma_pkg::OFF_DST:    dst_r[c] <= pwdata[AW-1:0];
                        dma_pkg::OFF_RELOAD: rld_r[c] <= pwdata[CW-1:0];
                        default: ;
                    endcase
                end
            end

            // Enable write wins over the end-of-count stop
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    en_r[c]    <= 1'b0;
                    first_r[c] <= 1'b0;
                end else if (en_one) begin
                    en_r[c]    <= 1'b1;
                    first_r[c] <= 1'b1;
                end else begin
                    if (wr_ctrl) begin
                        en_r[c] <= 1'b0;
                    end else if (fin_c[c] && !first_r[c] && cnt_r[c] == CW'(dma_pkg::CNT_ONE)) begin
                        en_r[c] <= 1'b0;
                    end
                    if (start_c[c]) begin
                        first_r[c] <= 1'b0;
                    end
                end
            end

            // Set wins over both clears so no request is lost
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flag_r[c] <= 1'b0;
                end else if (req[c]) begin
                    flag_r[c] <= 1'b1;
                end else if (start_c[c]) begin
                    flag_r[c] <= 1'b0;
                end else if (wr_ctrl && !pwdata[dma_pkg::B_REQ]) begin
                    flag_r[c] <= 1'b0;
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    fwd_r[c] <= '0;
                    cnt_r[c] <= '0;
                end else if (start_c[c] && first_r[c]) begin
                    fwd_r[c] <= fwd_eff;
                    cnt_r[c] <= rld_r[c];
                end else if (fin_c[c]) begin
                    fwd_r[c] <= fwd_r[c] + AW'(unit_r[c] ? dma_pkg::STEP_BYTE : dma_pkg::STEP_WORD);
                    cnt_r[c] <= cnt_r[c] - CW'(dma_pkg::CNT_ONE);
                end
            end
        end
    endgenerate

    // Engine: ties to channel 0, after a gap the other channel goes first
    assign pick  = ready[1] & (~ready[0] | (state_r == dma_pkg::ST_GAP && !chan_r));
    assign start = (state_r != dma_pkg::ST_XFER) & (|ready);
    assign fin   = (state_r == dma_pkg::ST_XFER) & (busy_r == '0);
    assign fwd_eff = first_r[pick] ? (fwdsel_r[pick] ? dst_r[pick] : src_r[pick]) : fwd_r[pick];
    assign cur_src = fwdsel_r[pick] ? src_r[pick] : fwd_eff;
    assign cur_dst = fwdsel_r[pick] ? fwd_eff : dst_r[pick];

    dma_cost u_rd_cost (
        .unit_byte (unit_r[pick]),
        .bus8      (bus8_r),
        .addr_odd  (cur_src[0]),
        .area      (srca_r[pick]),
        .cycles    (src_cyc)
    );

    dma_cost u_wr_cost (
        .unit_byte (unit_r[pick]),
        .bus8      (bus8_r),
        .addr_odd  (cur_dst[0]),
        .area      (dsta_r[pick]),
        .cycles    (dst_cyc)
    );

    assign cost_total = {1'b0, src_cyc} + {1'b0, dst_cyc};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= dma_pkg::ST_IDLE;
            busy_r  <= '0;
        end else begin
            unique case (state_r)
                dma_pkg::ST_IDLE,
                dma_pkg::ST_GAP: begin
                    if (start) begin
                        state_r <= dma_pkg::ST_XFER;
                        busy_r  <= cost_total - 5'h1;
                    end else begin
                        state_r <= dma_pkg::ST_IDLE;
                    end
                end
                dma_pkg::ST_XFER: begin
                    if (fin) begin
                        state_r <= dma_pkg::ST_GAP;
                    end else begin
                        busy_r <= busy_r - 5'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_r        <= 1'b0;
            dma_src_addr  <= '0;
            dma_dst_addr  <= '0;
            dma_unit_byte <= 1'b0;
        end else if (start) begin
            chan_r        <= pick;
            dma_src_addr  <= cur_src;
            dma_dst_addr  <= cur_dst;
            dma_unit_byte <= unit_r[pick];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_done <= 1'b0;
        end else begin
            dma_done <= fin;
        end
    end

    assign dma_bus_own = (state_r == dma_pkg::ST_XFER);
    assign dma_chan    = chan_r;

    // Checking helpers
    logic [4:0] len_r, cost_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            len_r  <= '0;
            cost_r <= '0;
        end else if (start) begin
            len_r  <= '0;
            cost_r <= cost_total;
        end else if (dma_bus_own) begin
            len_r <= len_r + 5'h1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_len;
        fin |-> len_r == cost_r - 5'h1;
    endproperty
    a_len: assert property (p_len) else $error("transfer length differs from cost");

    property p_mux;
        start && unit_r[pick] && srca_r[pick] == dma_pkg::AREA_MUX
            && dsta_r[pick] == dma_pkg::AREA_MUX |-> cost_total == 5'h6;
    endproperty
    a_mux: assert property (p_mux) else $error("multiplexed byte cost wrong");

    property p_byte;
        start && unit_r[pick] && srca_r[pick] == dma_pkg::AREA_INT_NW
            && dsta_r[pick] == dma_pkg::AREA_INT_NW |-> cost_total == 5'h2;
    endproperty
    a_byte: assert property (p_byte) else $error("byte cost not two");

    property p_word8;
        start && !unit_r[pick] && bus8_r && srca_r[pick] == dma_pkg::AREA_SEP_NW
            && dsta_r[pick] == dma_pkg::AREA_SEP_NW |-> cost_total == 5'h4;
    endproperty
    a_word8: assert property (p_word8) else $error("word cost on narrow bus wrong");

    property p_enable;
        g_ch[0].en_one |=> en_r[0] && first_r[0] ##1 (en_r[0] || $past(wr_c[0]));
    endproperty
    a_enable: assert property (p_enable) else $error("enable write did not arm channel");

    property p_reload;
        start_c[0] && first_r[0] |=> cnt_r[0] == $past(rld_r[0]) && !first_r[0] || $past(g_ch[0].en_one);
    endproperty
    a_reload: assert property (p_reload) else $error("counter not reloaded");

    property p_flag_set;
        req[0] |=> flag_r[0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("request flag not set");

    property p_flag_clr;
        start_c[0] && !req[0] |=> !flag_r[0];
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared at start");

    property p_sw_one;
        g_ch[0].wr_ctrl && pwdata[dma_pkg::B_REQ] && !flag_r[0] && !req[0] |=> !flag_r[0];
    endproperty
    a_sw_one: assert property (p_sw_one) else $error("software set the request flag");

    property p_prio;
        state_r == dma_pkg::ST_IDLE && ready[0] && ready[1] |-> !pick;
    endproperty
    a_prio: assert property (p_prio) else $error("channel 0 lost a tie");

    property p_gap;
        fin |=> !dma_bus_own ##1 (dma_bus_own || !(|$past(ready)));
    endproperty
    a_gap: assert property (p_gap) else $error("no processor cycle after transfer");

    c_both:    cover property (ready[0] && ready[1] ##[1:20] fin && chan_r);
    c_restart: cover property (g_ch[0].en_one && en_r[0]);
    c_odd:     cover property (start && cur_src[0] && !unit_r[pick]);
    c_stop:    cover property (fin_c[0] ##1 !en_r[0]);
endmodule

// File: design/dma_pkg.sv
// Purpose: Shared constants and types of the two-channel DMA control block
// Assumes: APB byte addresses, 8 address bits decoded
// Notes:   Channel registers repeat at a fixed stride
package dma_pkg;
    localparam int NCH      = 2;
    localparam int PAW      = 8;
    localparam int FSW      = 4;
    localparam int AREA_W   = 3;
    localparam int CH_BIT   = 5;
    localparam int CNT_ONE  = 1;

    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_FACTOR = 8'h04;
    localparam logic [7:0] OFF_SRC    = 8'h08;
    localparam logic [7:0] OFF_DST    = 8'h0c;
    localparam logic [7:0] OFF_RELOAD = 8'h10;
    localparam logic [7:0] OFF_COUNT  = 8'h14;
    localparam logic [7:0] OFF_FWD    = 8'h18;
    localparam logic [7:0] OFF_MASK   = 8'h1f;
    localparam logic [7:0] OFF_CFG    = 8'h40;

    localparam int B_EN     = 0;
    localparam int B_UNIT   = 1;
    localparam int B_FWD    = 2;
    localparam int B_REQ    = 3;
    localparam int B_SWT    = 4;
    localparam int B_SRCA   = 5;
    localparam int B_DSTA   = 8;
    localparam int B_BUS8   = 0;

    localparam logic [3:0] FAC_SW  = 4'h8;
    localparam logic [3:0] FAC_EXT = 4'h9;

    localparam logic [2:0] AREA_INT_NW = 3'h0;
    localparam logic [2:0] AREA_INT_W  = 3'h1;
    localparam logic [2:0] AREA_SFR    = 3'h2;
    localparam logic [2:0] AREA_SEP_NW = 3'h3;
    localparam logic [2:0] AREA_SEP_W  = 3'h4;
    localparam logic [2:0] AREA_MUX    = 3'h5;

    localparam logic [1:0] COEF_FAST = 2'h1;
    localparam logic [1:0] COEF_WAIT = 2'h2;
    localparam logic [1:0] COEF_MUX  = 2'h3;
    localparam logic [1:0] N_ONE     = 2'h1;
    localparam logic [1:0] N_TWO     = 2'h2;
    localparam logic [1:0] STEP_BYTE = 2'h1;
    localparam logic [1:0] STEP_WORD = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_XFER = 3'b010,
        ST_GAP  = 3'b100
    } eng_state_e;
endpackage

// File: design/dma_cost.sv
// Purpose: Bus cycles spent on one side (read or write) of a transfer unit
// Assumes: Area code selects the wait coefficient
// Notes:   Unknown area codes cost as fast memory
`timescale 1ns/10ps
module dma_cost (
    input  wire logic       unit_byte,
    input  wire logic       bus8,
    input  wire logic       addr_odd,
    input  wire logic [2:0] area,
    output logic      [3:0] cycles
);
    logic [1:0] n;
    logic [1:0] coef;

    always_comb begin
        n = (unit_byte || !(bus8 || addr_odd)) ? dma_pkg::N_ONE : dma_pkg::N_TWO;
        unique case (area)
            dma_pkg::AREA_INT_W,
            dma_pkg::AREA_SFR,
            dma_pkg::AREA_SEP_W: coef = dma_pkg::COEF_WAIT;
            dma_pkg::AREA_MUX:   coef = dma_pkg::COEF_MUX;
            default:             coef = dma_pkg::COEF_FAST;
        endcase
        cycles = {2'b00, n} * {2'b00, coef};
    end
endmodule

// File: design/dma_req_sel.sv
// Purpose: Picks one request factor for a channel and forms a request pulse
// Assumes: Peripheral requests arrive as one-cycle pulses, pins synchronous
// Notes:   External factor fires on the rising edge of its pin
`timescale 1ns/10ps
module dma_req_sel #(
    parameter int NPER = 8
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic [3:0]      factor,
    input  wire logic [NPER-1:0] periph_irq,
    input  wire logic            sw_trig,
    input  wire logic            ext_in,
    output logic                 req_pulse
);
    logic ext_d_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_d_r <= 1'b0;
        end else begin
            ext_d_r <= ext_in;
        end
    end

    // Peripheral pulses pass straight through so the flag sets with the irq
    always_comb begin
        req_pulse = 1'b0;
        for (int i = 0; i < NPER; i++) begin
            if (factor == 4'(i)) begin
                req_pulse = periph_irq[i];
            end
        end
        if (factor == dma_pkg::FAC_SW) begin
            req_pulse = sw_trig;
        end
        if (factor == dma_pkg::FAC_EXT) begin
            req_pulse = ext_in & ~ext_d_r;
        end
    end
endmodule

// File: tb/dma_far_model.sv
// Purpose: Far side: request sources and an observer of the memory bus
// Assumes: Sources change right after rising pclk
// Notes:   Times each transfer's bus hold and keeps its channel and source
`timescale 1ns/10ps
module dma_far_model #(
    parameter int AW = 20
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          dma_bus_own,
    input  wire logic          dma_chan,
    input  wire logic [AW-1:0] dma_src_addr,
    output logic      [7:0]    periph_irq,
    output logic      [1:0]    ext_pin
);
    int            run_r;
    int            len_r;
    logic          chan_r;
    logic [AW-1:0] src_r;

    initial begin
        periph_irq = '0;
        ext_pin = '0;
    end

    // Length latched once the bus is handed back
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_r <= 0;
            len_r <= 0;
        end else if (dma_bus_own) begin
            run_r <= run_r + 1;
            if (run_r == 0) begin
                chan_r <= dma_chan;
                src_r <= dma_src_addr;
            end
        end else if (run_r != 0) begin
            len_r <= run_r;
            run_r <= 0;
        end
    end

    task automatic pulse_irq(input logic [2:0] idx);
        periph_irq[idx] <= 1'b1;
        @(posedge pclk);
        periph_irq <= '0;
    endtask

    // Pins dropped first so that a rising edge is seen
    task automatic raise_ext(input logic [1:0] m);
        ext_pin <= '0;
        @(posedge pclk);
        ext_pin <= m;
        @(posedge pclk);
    endtask
endmodule

// File: tb/dma_channel_control_tb.sv
// Purpose: Self-checking bench of the two-channel DMA control block
// Assumes: Zero-wait APB slave, default parameters
// Notes:   Bus cost measured by the far-side model
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
    $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module dma_channel_control_tb;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        pready;
    logic        pslverr;
    logic        perr;
    logic        done;
    logic        b8;
    logic        ub;
    logic [2:0]  sa;
    logic [2:0]  da;
    logic [7:0]  paddr;
    logic [7:0]  irq;
    logic [1:0]  ext;
    logic [19:0] src;
    logic [19:0] dst;
    logic [19:0] src_o;
    logic [19:0] dst_o;
    logic        ub_o;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] q;
    logic [31:0] seed;
    logic        own;
    logic        chan;
    int          fails;
    int          total_checks;
    int          cyc;

    dma_channel_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .periph_irq(irq),
        .external_interrupt_input(ext), .dma_bus_own(own), .dma_chan(chan), .dma_src_addr(src_o),
        .dma_dst_addr(dst_o), .dma_unit_byte(ub_o), .dma_done(done));
    dma_far_model FAR (.pclk(pclk), .presetn(presetn), .dma_bus_own(own), .dma_chan(chan),
        .dma_src_addr(src_o), .periph_irq(irq), .ext_pin(ext));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int coef(input logic [2:0] a);
        return (a == 3'h5) ? 3 : (a == 3'h1 || a == 3'h2 || a == 3'h4) ? 2 : 1;
    endfunction
    function automatic int sides(input logic u, input logic w8, input logic odd);
        return (u || (!w8 && !odd)) ? 1 : 2;
    endfunction

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (done !== 1'b1 && n < 300);
        `CHK(done, 1'b1)
        // Far model latches the run length one edge later
        @(posedge pclk);
    endtask

    task print_verdict();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            print_verdict();
        end
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        seed = 32'h0001_7750;
        fails = 0;
        total_checks = 0;
        cyc = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1, dma_pkg::OFF_FACTOR, 32'h0000_0008);
        // Random costs; first pass is odd word on a 16-bit mux bus
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            {b8, ub, sa, da, src} = (i == 0) ? {1'b0, 1'b0, 3'h5, 3'h5, 20'h0_0003} : seed[27:0];
            seed = lfsr(seed);
            dst = seed[19:0];
            apb(1, dma_pkg::OFF_CFG, {31'h0, b8});
            apb(1, dma_pkg::OFF_SRC, {12'h0, src});
            apb(1, dma_pkg::OFF_DST, {12'h0, dst});
            apb(1, dma_pkg::OFF_CTRL, {21'h0, da, sa, 2'b10, seed[20], ub, 1'b1});
            wait_done();
            `CHK(FAR.len_r, sides(ub, b8, src[0]) * coef(sa) + sides(ub, b8, dst[0]) * coef(da))
            `CHK(FAR.src_r, src)
            `CHK(dst_o, dst)
            `CHK(ub_o, ub)
        end
        // Peripheral factor, counter reload and pointer stepping
        apb(1, dma_pkg::OFF_RELOAD, 32'h0000_0005);
        apb(1, dma_pkg::OFF_FACTOR, {29'h0, seed[2:0]});
        apb(1, dma_pkg::OFF_CTRL, 32'h0000_0001);
        for (int i = 0; i < 2; i++) begin
            FAR.pulse_irq(seed[2:0]);
            wait_done();
            `CHK(FAR.src_r, src + 20'(2 * i))
            apb(0, dma_pkg::OFF_COUNT, 32'h0);
            `CHK(q[15:0], 16'(4 - i))
        end
        // Request flag while disabled, software clear, start on enable
        apb(1, dma_pkg::OFF_FACTOR, 32'h0000_0008);
        apb(1, dma_pkg::OFF_CTRL, 32'h0000_0010);
        apb(0, dma_pkg::OFF_CTRL, 32'h0);
        `CHK(q[3], 1'b1)
        apb(1, dma_pkg::OFF_CTRL, 32'h0000_0008);
        apb(0, dma_pkg::OFF_CTRL, 32'h0);
        `CHK(q[3], 1'b1)
        apb(1, dma_pkg::OFF_CTRL, 32'h0000_0000);
        apb(0, dma_pkg::OFF_CTRL, 32'h0);
        `CHK(q[3], 1'b0)
        apb(1, dma_pkg::OFF_CTRL, 32'h0000_0010);
        apb(1, dma_pkg::OFF_CTRL, 32'h0000_0009);
        wait_done();
        apb(0, dma_pkg::OFF_CTRL, 32'h0);
        `CHK(q[3], 1'b0)
        `CHK(q[0], 1'b1)
        // Both channels on their pins in the same cycle
        apb(1, dma_pkg::OFF_FACTOR, 32'h0000_0009);
        apb(1, 8'h24, 32'h0000_0009);
        apb(1, dma_pkg::OFF_CTRL, 32'h0000_0001);
        apb(1, 8'h20, 32'h0000_0001);
        FAR.raise_ext(2'b11);
        wait_done();
        `CHK(FAR.chan_r, 1'b0)
        wait_done();
        `CHK(FAR.chan_r, 1'b1)
        apb(0, 8'h1c, 32'h0);
        `CHK(perr, 1'b1)
        `CHK(q, 32'h0000_0000)
        print_verdict();
    end
endmodule
